/* design/lbui_defines.svh */
// offsets, field layout, reset values and counts of the update-interval block
// assumes inclusion by bare name from the package and design files
`ifndef LBUI_DEFINES_SVH
`define LBUI_DEFINES_SVH

// register byte offsets
`define LBUI_OFF_CFG 12'h000
`define LBUI_OFF_STATUS 12'h004
`define LBUI_OFF_INTERVAL 12'h010

// configuration field positions
`define LBUI_CFG_ASYM_BIT 0
`define LBUI_CFG_UPD_EN_BIT 1

// status field positions
`define LBUI_ST_SEG_LSB 0
`define LBUI_ST_FIELD_LSB 4
`define LBUI_ST_CNT_LSB 8

// reset values
`define LBUI_INTERVAL_RESET 32'h0000_0000
`define LBUI_CFG_RESET 2'h0
`define LBUI_CNT_RESET 4'h0

// layout defaults
`define LBUI_NUM_SEG 8
`define LBUI_FIELD_W 4
`define LBUI_SEG_W 3
`define LBUI_ADDR_W 12

`endif

/* design/lbui_pkg.sv */
// types shared by the update-interval block
// assumes the defines header sits beside this file
`include "lbui_defines.svh"

package lbui_pkg;

   // apb request as seen by the slave
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`LBUI_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } lbui_apb_req_t;

   // apb answer of the slave
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } lbui_apb_rsp_t;

   // what the breathing engine reports each cycle
   typedef struct packed {
      logic period_end;
      logic falling_ramp;
      logic [7:0] duty;
   } lbui_pwm_in_t;

endpackage

/* design/lbui_interval_reg.sv */
// shadow and active copies of the segment interval register
// assumes writes and commit strobes are one-cycle pulses on pclk
`timescale 1ns/1ps
`include "lbui_defines.svh"

module lbui_interval_reg #(
   parameter int NUM_SEG = `LBUI_NUM_SEG,
   parameter int FIELD_W = `LBUI_FIELD_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // software side
   input wire logic wr_en,
   input wire logic [NUM_SEG*FIELD_W-1:0] wr_data,
   // engine side
   input wire logic commit,
   output logic [NUM_SEG*FIELD_W-1:0] active
);
   import lbui_pkg::*;

   logic [NUM_SEG*FIELD_W-1:0] shadow;
   logic [NUM_SEG*FIELD_W-1:0] next_shadow;
   logic [NUM_SEG*FIELD_W-1:0] next_active;

   // refuse layouts that do not fill one bus word
   if (NUM_SEG * FIELD_W != 32)
   begin : g_chk
      $error("interval layout must fill 32 bits");
   end

   // writes land in the shadow at any time, commit copies it over
   always_comb
   begin
      next_shadow = shadow;
      next_active = active;
      if (wr_en)
      begin
         next_shadow = wr_data;
      end
      if (commit)
      begin
         next_active = shadow;
      end
   end

   // both copies clear to one-period spacing
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shadow <= `LBUI_INTERVAL_RESET;
         active <= `LBUI_INTERVAL_RESET;
      end
      else
      begin
         shadow <= next_shadow;
         active <= next_active;
      end
   end

   // a write is always held in the shadow
   shadow_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_en |=> shadow == $past(wr_data))
      else $error("shadow missed a write");

   // active only moves on a commit, and then takes the shadow
   active_commit_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      commit |=> active == $past(shadow))
      else $error("commit did not copy shadow");

   active_hold_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !commit |=> $stable(active))
      else $error("active changed without commit");

endmodule

/* design/lbui_top.sv */
// apb slave and update-interval selection for the led breathing engine
// assumes engine inputs are synchronous to pclk and period_end is a pulse
//
// Contract
// - eight 4-bit fields, one picked by index
// - symmetric: index is duty bits 7..5
// - asymmetric: index is falling flag, duty 7..6
// - interval writes accepted at any moment
// - shadow commits at period end when enabled
// - interval reads return active, not shadow
// - field n waits n plus one periods
// - field k sits in bits 4k+3..4k
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "lbui_defines.svh"

module lbui_top #(
   parameter int NUM_SEG = `LBUI_NUM_SEG,
   parameter int FIELD_W = `LBUI_FIELD_W
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire lbui_pkg::lbui_apb_req_t apb_req,
   output lbui_pkg::lbui_apb_rsp_t apb_rsp,
   // breathing engine
   input wire lbui_pkg::lbui_pwm_in_t pwm_in,
   output logic update_due
);
   import lbui_pkg::*;

   localparam int SEG_W = `LBUI_SEG_W;
   localparam logic [1:0] CFG_RST = `LBUI_CFG_RESET;

   // refuse sizes the index logic cannot address
   if (NUM_SEG != (1 << SEG_W) || FIELD_W != `LBUI_FIELD_W)
   begin : g_chk
      $error("top supports eight 4-bit fields only");
   end

   logic asym;
   logic upd_en;
   logic next_asym;
   logic next_upd_en;
   logic [31:0] prdata;
   logic [31:0] next_prdata;
   logic [31:0] active;
   logic [SEG_W-1:0] seg_index;
   logic [FIELD_W-1:0] field [NUM_SEG];
   logic [FIELD_W-1:0] sel_field;
   logic [FIELD_W-1:0] period_cnt;
   logic [FIELD_W-1:0] next_period_cnt;
   logic setup;
   logic access;
   logic wr_cfg;
   logic wr_interval;
   logic mapped;
   logic commit;
   logic [4:0] gap_cnt;
   logic [4:0] next_gap_cnt;

   // apb phase decode and address match
   assign setup = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable;
   assign mapped = (apb_req.paddr == `LBUI_OFF_CFG) ||
                   (apb_req.paddr == `LBUI_OFF_STATUS) ||
                   (apb_req.paddr == `LBUI_OFF_INTERVAL);
   assign wr_cfg = access && apb_req.pwrite &&
                   (apb_req.paddr == `LBUI_OFF_CFG);
   assign wr_interval = access && apb_req.pwrite &&
                        (apb_req.paddr == `LBUI_OFF_INTERVAL);

   // zero-wait answer, error on unmapped addresses
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = access && !mapped;
   assign apb_rsp.prdata = prdata;

   // segment index from duty and ramp direction
   always_comb
   begin
      if (asym)
      begin
         seg_index = {pwm_in.falling_ramp, pwm_in.duty[7:6]};
      end
      else
      begin
         seg_index = pwm_in.duty[7:5];
      end
   end

   // split the active word into its fields
   for (genvar k = 0; k < NUM_SEG; k++)
   begin : g_field
      assign field[k] = active[k*FIELD_W +: FIELD_W];
   end

   // pick the field of the current segment
   assign sel_field = field[seg_index];

   // commit point for the shadow copy
   assign commit = pwm_in.period_end && upd_en;

   // shadow and active interval copies
   lbui_interval_reg #(
      .NUM_SEG(NUM_SEG),
      .FIELD_W(FIELD_W)
   ) u_interval (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_interval),
      .wr_data(apb_req.pwdata),
      .commit(commit),
      .active(active)
   );

   // period counter: due once the count reaches the chosen field
   always_comb
   begin
      update_due = pwm_in.period_end && (period_cnt >= sel_field);
      next_period_cnt = period_cnt;
      if (update_due)
      begin
         next_period_cnt = `LBUI_CNT_RESET;
      end
      else if (pwm_in.period_end)
      begin
         next_period_cnt = period_cnt + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         period_cnt <= `LBUI_CNT_RESET;
      end
      else
      begin
         period_cnt <= next_period_cnt;
      end
   end

   // configuration bits written in the access phase, read data captured in the setup phase
   always_comb
   begin
      next_asym = asym;
      next_upd_en = upd_en;
      next_prdata = prdata;
      if (wr_cfg)
      begin
         next_asym = apb_req.pwdata[`LBUI_CFG_ASYM_BIT];
         next_upd_en = apb_req.pwdata[`LBUI_CFG_UPD_EN_BIT];
      end
      if (setup)
      begin
         next_prdata = 32'h0000_0000;
         case (apb_req.paddr)
            `LBUI_OFF_CFG:
            begin
               next_prdata[`LBUI_CFG_ASYM_BIT] = asym;
               next_prdata[`LBUI_CFG_UPD_EN_BIT] = upd_en;
            end
            `LBUI_OFF_STATUS:
            begin
               next_prdata[`LBUI_ST_SEG_LSB +: SEG_W] = seg_index;
               next_prdata[`LBUI_ST_FIELD_LSB +: FIELD_W] = sel_field;
               next_prdata[`LBUI_ST_CNT_LSB +: FIELD_W] = period_cnt;
            end
            `LBUI_OFF_INTERVAL:
            begin
               next_prdata = active;
            end
            default:
            begin
               next_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         asym <= CFG_RST[`LBUI_CFG_ASYM_BIT];
         upd_en <= CFG_RST[`LBUI_CFG_UPD_EN_BIT];
         prdata <= 32'h0000_0000;
      end
      else
      begin
         asym <= next_asym;
         upd_en <= next_upd_en;
         prdata <= next_prdata;
      end
   end

   // reference count of period ends since the last update, for the checks
   always_comb
   begin
      next_gap_cnt = gap_cnt;
      if (update_due)
      begin
         next_gap_cnt = 5'h00;
      end
      else if (pwm_in.period_end)
      begin
         next_gap_cnt = gap_cnt + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_cnt <= 5'h00;
      end
      else
      begin
         gap_cnt <= next_gap_cnt;
      end
   end

   // checks on index, selection, spacing and register views
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   seg_sym_a: assert property (!asym |-> seg_index == pwm_in.duty[7:5])
      else $error("symmetric index wrong");

   seg_asym_a: assert property (asym |->
      seg_index == {pwm_in.falling_ramp, pwm_in.duty[7:6]})
      else $error("asymmetric index wrong");

   field_pick_a: assert property (
      sel_field == active[4*seg_index +: 4])
      else $error("wrong field selected");

   top_field_a: assert property (seg_index == 3'h7 |->
      sel_field == active[31:28])
      else $error("top segment field misplaced");

   // spacing is judged against the independent reference count
   due_spacing_a: assert property (update_due |->
      gap_cnt >= {1'b0, sel_field})
      else $error("update came too early");

   no_late_due_a: assert property (pwm_in.period_end &&
      gap_cnt >= {1'b0, sel_field} |-> update_due)
      else $error("update came too late");

   cnt_restart_a: assert property (update_due |=>
      period_cnt == 4'h0)
      else $error("counter not restarted");

   cnt_step_a: assert property (pwm_in.period_end && !update_due |=>
      period_cnt == $past(period_cnt) + 4'h1)
      else $error("counter missed a period");

   read_active_a: assert property (setup && !apb_req.pwrite &&
      apb_req.paddr == `LBUI_OFF_INTERVAL |=> prdata == $past(active))
      else $error("interval read not active copy");

   write_any_a: assert property (wr_interval && !commit
      ##1 commit |=> active == $past(apb_req.pwdata, 2))
      else $error("written value not committed");

   reset_clear_a: assert property ($rose(presetn) |->
      active == 32'h0000_0000 && period_cnt == 4'h0)
      else $error("reset did not clear fields");

   // main scenarios
   cov_asym_fall_c: cover property (asym && pwm_in.falling_ramp &&
      update_due);
   cov_long_wait_c: cover property (update_due && sel_field == 4'hf);
   cov_commit_c: cover property (wr_interval ##[1:20] commit);
   cov_bad_addr_c: cover property (apb_rsp.pslverr);

endmodule

/* verif/lbui_top_tb.sv */
// self-checking bench for the update-interval block
// assumes lbui_pkg and the defines header are compiled first
`timescale 1ns/1ps
`include "lbui_defines.svh"

module lbui_top_tb;
   import lbui_pkg::*;

   logic pclk;
   logic presetn;
   lbui_apb_req_t apb_req;
   lbui_apb_rsp_t apb_rsp;
   lbui_pwm_in_t pwm_in;
   logic update_due;
   int n_errors;
   int total_checks;
   int cycles;
   logic [31:0] rd;
   logic err;

   // device under test
   lbui_top i_lbui_top (
      .pclk(pclk),
      .presetn(presetn),
      .apb_req(apb_req),
      .apb_rsp(apb_rsp),
      .pwm_in(pwm_in),
      .update_due(update_due)
   );

   // 100 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // hang guard
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         final_report();
      end
   end

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // one period_end pulse, update_due sampled in its cycle
   task automatic pulse(output logic due);
      @(posedge pclk);
      pwm_in.period_end <= 1'b1;
      @(posedge pclk);
      due = update_due;
      pwm_in.period_end <= 1'b0;
   endtask

   // periods up to and including the next update
   task automatic count_due(output int c);
      logic due;
      c = 0;
      due = 1'b0;
      while (due !== 1'b1 && c < 20)
      begin
         pulse(due);
         c++;
      end
   endtask

   // writes go to shadow, reads show active until commit
   task automatic t_shadow();
      logic due;
      apb(1'b1, `LBUI_OFF_INTERVAL, 32'hF654_3210);
      pulse(due);
      apb(1'b0, `LBUI_OFF_INTERVAL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, `LBUI_OFF_CFG, 32'h0000_0002);
      pulse(due);
      apb(1'b0, `LBUI_OFF_INTERVAL, 32'h0000_0000);
      chk(rd, 32'hF654_3210);
   endtask

   // set index inputs, check status index and field, then update spacing
   task automatic t_seg(input logic fall, input logic [7:0] duty,
                        input logic [2:0] idx, input int periods);
      int c;
      count_due(c);
      pwm_in.falling_ramp <= fall;
      pwm_in.duty <= duty;
      apb(1'b0, `LBUI_OFF_STATUS, 32'h0000_0000);
      chk({29'h0000_0000, rd[2:0]}, {29'h0000_0000, idx});
      chk({28'h000_0000, rd[7:4]}, 32'(periods - 1));
      count_due(c);
      chk(c, periods);
   endtask

   // after reset the interval reads zero and a mapped read has no error
   task automatic t_reset_read();
      apb(1'b0, `LBUI_OFF_INTERVAL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0000);
   endtask

   // a write followed at once by a period end is committed by it
   task automatic t_write_commit();
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, 1'b1, `LBUI_OFF_INTERVAL, 32'h1234_5670};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (apb_rsp.pready !== 1'b1);
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      pwm_in.period_end <= 1'b1;
      @(posedge pclk);
      pwm_in.period_end <= 1'b0;
      apb(1'b0, `LBUI_OFF_INTERVAL, 32'h0000_0000);
      chk(rd, 32'h1234_5670);
   endtask

   // an unmapped address answers with an error and zero data
   task automatic t_bad_addr();
      apb(1'b0, 12'h020, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
   endtask

   // second reset clears shadow as well as active
   task automatic t_mid_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, `LBUI_OFF_CFG, 32'h0000_0002);
      t_seg(1'b0, 8'hE0, 3'h7, 1);
      apb(1'b0, `LBUI_OFF_INTERVAL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
   endtask

   // verdict
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // main sequence
   initial
   begin
      presetn = 1'b0;
      apb_req = '0;
      pwm_in = '0;
      n_errors = 0;
      total_checks = 0;
      cycles = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_read();
      t_shadow();
      for (int k = 0; k < 8; k++)
         t_seg(1'b0, 8'(k * 32), 3'(k), (k == 7) ? 16 : k + 1);
      apb(1'b1, `LBUI_OFF_CFG, 32'h0000_0003);
      t_seg(1'b1, 8'h80, 3'h6, 7);
      t_seg(1'b0, 8'hC0, 3'h3, 4);
      t_write_commit();
      t_bad_addr();
      t_mid_reset();
      final_report();
   end

endmodule
